// ==== srdl_checker.sv ====
`timescale 1ns/1ps
module srdl_checker (
    input logic        sys_clk_i,   // clock
    input logic        sys_rst_i,   // sync reset
    input logic        mem_we_o,    // write request
    input logic [15:0] mem_addr_o,  // write address
    input logic [7:0]  mem_data_o,  // write byte
    input logic        mem_ready_i, // memory takes write
    input logic        loading_o,   // first S1 seen
    input logic        done_o,      // transfer ended
    input logic [15:0] entry_o,     // entry address
    input logic        err_o        // sticky error
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);
    property p_we_hold;
        mem_we_o && !mem_ready_i |=> mem_we_o && $stable(mem_addr_o) && $stable(mem_data_o);
    endproperty
    a_we_hold: assert property (p_we_hold) else $error("write dropped or changed while stalled");
    property p_no_early_write;
        mem_we_o |-> loading_o;
    endproperty
    a_no_early_write: assert property (p_no_early_write) else $error("write before loading");
    property p_no_write_done;
        done_o |-> !mem_we_o;
    endproperty
    a_no_write_done: assert property (p_no_write_done) else $error("write after end record");
    property p_done_sticky;
        done_o |=> done_o;
    endproperty
    a_done_sticky: assert property (p_done_sticky) else $error("done fell");
    property p_err_sticky;
        err_o |=> err_o;
    endproperty
    a_err_sticky: assert property (p_err_sticky) else $error("error fell");
    property p_load_sticky;
        loading_o |=> loading_o;
    endproperty
    a_load_sticky: assert property (p_load_sticky) else $error("loading fell");
    property p_done_needs_load;
        $rose(done_o) |-> loading_o && $past(loading_o);
    endproperty
    a_done_needs_load: assert property (p_done_needs_load) else $error("done without loading");
    property p_entry_stable;
        done_o |=> $stable(entry_o);
    endproperty
    a_entry_stable: assert property (p_entry_stable) else $error("entry moved after done");
endmodule // srdl_checker

// ==== srdl_defines.vh ====
`ifndef SRDL_DEFINES_VH
`define SRDL_DEFINES_VH

// ascii characters seen on the host stream
`define SRDL_CH_S        8'h53
`define SRDL_CH_CR       8'h0D
`define SRDL_CH_LF       8'h0A
`define SRDL_CH_NUL      8'h00
`define SRDL_CH_0        8'h30
`define SRDL_CH_9        8'h39
`define SRDL_CH_UA       8'h41
`define SRDL_CH_UF       8'h46
`define SRDL_CH_LA       8'h61
`define SRDL_CH_LF_HEX   8'h66

// record type digits
`define SRDL_T_HDR       4'h0
`define SRDL_T_DATA16    4'h1
`define SRDL_T_DATA24    4'h2
`define SRDL_T_DATA32    4'h3
`define SRDL_T_COUNT     4'h5
`define SRDL_T_END32     4'h7
`define SRDL_T_END24     4'h8
`define SRDL_T_END16     4'h9

// address field widths in bytes
`define SRDL_ALEN_2      3'h2
`define SRDL_ALEN_3      3'h3
`define SRDL_ALEN_4      3'h4

// length byte plus address, data and checksum must sum to this
`define SRDL_SUM_GOOD    8'hFF

// fifo in the character path
`define SRDL_FIFO_DEPTH  16
`define SRDL_FIFO_AW     4

`endif

// ==== srdl_fifo.v ====
`timescale 1ns/1ps
`include "srdl_defines.vh"

module srdl_fifo #(
    parameter W  = 8,
    parameter D  = `SRDL_FIFO_DEPTH,
    parameter AW = `SRDL_FIFO_AW
) (
    input  wire          sys_clk_i,   // clock
    input  wire          sys_rst_i,   // sync reset, active high
    input  wire          in_valid_i,  // write side valid
    output reg           in_ready_o,  // write side ready, registered
    input  wire [W-1:0]  in_data_i,   // write data
    output wire          out_valid_o, // read side valid
    input  wire          out_ready_i, // read side ready
    output wire [W-1:0]  out_data_o   // read data
);
    reg [W-1:0]  mem [0:D-1];
    reg [AW-1:0] wp;
    reg [AW-1:0] rp;
    reg [AW:0]   cnt;
    wire         push = in_valid_i & in_ready_o;
    wire         pop  = out_valid_o & out_ready_i;
    wire [AW:0]  next_cnt = cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

    assign out_valid_o = (cnt != {(AW+1){1'b0}});
    assign out_data_o  = mem[rp];

    always @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            wp         <= {AW{1'b0}};
            rp         <= {AW{1'b0}};
            cnt        <= {(AW+1){1'b0}};
            in_ready_o <= 1'b0;
        end else begin
            if (push) begin
                mem[wp] <= in_data_i;
                wp      <= (wp == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp + 1'b1;
            end
            if (pop)
                rp <= (rp == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp + 1'b1;
            cnt        <= next_cnt;
            // ready is registered so it never depends on the reader in the same cycle
            in_ready_o <= (next_cnt != D[AW:0]);
        end
    end
endmodule // srdl_fifo

// ==== srdl_host.sv ====
`timescale 1ns/1ps
module srdl_host (
    input  logic       sys_clk_i,    // clock
    input  logic       char_ready_i, // loader takes a char
    output logic       char_valid_o, // char offered
    output logic [7:0] char_o,       // ascii char
    output logic       stuck_o       // char never taken
);
    initial begin
        char_valid_o = 1'b0;
        char_o = 8'h00;
        stuck_o = 1'b0;
    end
    // every char goes out as its ascii code, held until taken
    task automatic send(input string s);
        int n;
        for (int i = 0; i < s.len(); i++) begin
            @(negedge sys_clk_i);
            char_valid_o = 1'b1;
            char_o = s[i];
            n = 0;
            while (!char_ready_i && n < 500) begin
                @(negedge sys_clk_i);
                n++;
            end
            if (n >= 500) stuck_o = 1'b1;
            @(posedge sys_clk_i);
        end
        @(negedge sys_clk_i);
        char_valid_o = 1'b0;
        // released line must not look like a held char
        char_o = ~char_o;
    endtask
endmodule // srdl_host

// ==== srdl_loader.v ====
`timescale 1ns/1ps
`include "srdl_defines.vh"

// Notes on behaviour
// - only S1 data and S9 end are loaded
// - everything before first S1 is discarded
// - after first S1 only S1; S9 ends
// - S0 is a header, skipped, address ignored
// - S1/S2/S3 carry 2/3/4 address bytes
// - S5 count record parsed, not loaded
// - S7/S8/S9 end records, 4/3/2 address bytes
// - S9 zero address uses first entry point
// - several header records are tolerated
// - length counts following byte pairs
// - S9 with zero address has length 03
// - data bytes go to consecutive addresses
// - every character arrives as ascii code
// - high nibble character first, then low
// - checksum is complement of byte sum
// - CR, LF, NUL separate records
module srdl_loader #(
    parameter FIFO_DEPTH = `SRDL_FIFO_DEPTH,
    parameter FIFO_AW    = `SRDL_FIFO_AW
) (
    input  wire        sys_clk_i,    // clock, 10 MHz
    input  wire        sys_rst_i,    // sync reset, active high
    input  wire        char_valid_i, // host character valid
    input  wire [7:0]  char_i,       // host character, ascii
    output wire        char_ready_o, // character accepted when high
    output reg         mem_we_o,     // memory write request
    output reg  [15:0] mem_addr_o,   // memory write address
    output reg  [7:0]  mem_data_o,   // memory write data
    input  wire        mem_ready_i,  // memory takes the write
    output reg         loading_o,    // first S1 seen
    output reg         done_o,       // transfer ended by good S9
    output reg  [15:0] entry_o,      // execution entry address
    output reg         err_o         // sticky error
);
    localparam ST_IDLE = 2'b00;
    localparam ST_TYPE = 2'b01;
    localparam ST_BODY = 2'b10;
    localparam ST_DONE = 2'b11;

    function is_hex;
        input [7:0] c;
        begin
            is_hex = (c >= `SRDL_CH_0  && c <= `SRDL_CH_9)  ||
                     (c >= `SRDL_CH_UA && c <= `SRDL_CH_UF) ||
                     (c >= `SRDL_CH_LA && c <= `SRDL_CH_LF_HEX);
        end
    endfunction

    function [3:0] hex_val;
        input [7:0] c;
        begin
            if (c <= `SRDL_CH_9)
                hex_val = c[3:0];
            else
                hex_val = c[3:0] + 4'h9;
        end
    endfunction

    function [2:0] addr_len;
        input [3:0] t;
        begin
            case (t)
                `SRDL_T_DATA24, `SRDL_T_END24: addr_len = `SRDL_ALEN_3;
                `SRDL_T_DATA32, `SRDL_T_END32: addr_len = `SRDL_ALEN_4;
                default:                       addr_len = `SRDL_ALEN_2;
            endcase
        end
    endfunction

    // record type is a single decimal digit
    function is_digit;
        input [7:0] c;
        begin
            is_digit = (c >= `SRDL_CH_0) && (c <= `SRDL_CH_9);
        end
    endfunction

    // terminators that may stand between records
    function is_sep;
        input [7:0] c;
        begin
            is_sep = (c == `SRDL_CH_CR)  ||
                     (c == `SRDL_CH_LF)  ||
                     (c == `SRDL_CH_NUL);
        end
    endfunction

    // checksum arithmetic stays eight bits, carries drop
    function [7:0] sum_add;
        input [7:0] a;
        input [7:0] b;
        begin
            sum_add = a + b;
        end
    endfunction

    // last two address bytes, high byte first
    function [15:0] join16;
        input [7:0] hi;
        input [7:0] lo;
        begin
            join16 = {hi, lo};
        end
    endfunction

    wire       fifo_ready;
    wire       fifo_valid;
    wire [7:0] fifo_data;
    // a pending write that memory has not taken stalls the parser
    wire       stall = mem_we_o & ~mem_ready_i;
    wire       take  = fifo_valid & ~stall;

    srdl_fifo #(
        .W  (8),
        .D  (FIFO_DEPTH),
        .AW (FIFO_AW)
    ) u_fifo (
        .sys_clk_i   (sys_clk_i),
        .sys_rst_i   (sys_rst_i),
        .in_valid_i  (char_valid_i),
        .in_ready_o  (fifo_ready),
        .in_data_i   (char_i),
        .out_valid_o (fifo_valid),
        .out_ready_i (take),
        .out_data_o  (fifo_data)
    );

    assign char_ready_o = fifo_ready;

    reg  [1:0]  state;
    reg  [3:0]  rtype;
    reg  [2:0]  alen;
    reg         nib_lo;
    reg  [3:0]  hi_nib;
    reg         len_seen;
    reg  [7:0]  len;
    reg  [7:0]  idx;
    reg  [7:0]  sum;
    reg  [31:0] addr;
    reg  [15:0] wr_ptr;
    reg         have_first;
    reg  [15:0] first_addr;

    wire [7:0]  cbyte   = {hi_nib, hex_val(fifo_data)};
    wire [7:0]  alen8   = {5'h00, alen};
    wire        hex_ok  = is_hex(fifo_data);
    wire        is_load = (rtype == `SRDL_T_DATA16);
    wire        is_end  = (rtype == `SRDL_T_END16);
    wire [15:0] addr16  = addr[15:0];
    // running sum and the address as they read after this byte
    wire [7:0]  sum_next  = sum_add(sum, cbyte);
    wire [15:0] addr_next = join16(addr[7:0], cbyte);

    // a byte completes on each low-nibble character inside a record
    wire        pair_done = take && (state == ST_BODY) && hex_ok && nib_lo;
    wire        at_cksum  = len_seen && (idx == len - 8'h01);
    // only S1 data reaches memory
    wire        wr_req    = pair_done && len_seen && !at_cksum && (idx >= alen8) && is_load;

    // a request holds until memory takes it; the parser stalls meanwhile
    always @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            mem_we_o   <= 1'b0;
            mem_addr_o <= 16'h0000;
            mem_data_o <= 8'h00;
        end else if (wr_req) begin
            mem_we_o   <= 1'b1;
            mem_addr_o <= wr_ptr;
            mem_data_o <= cbyte;
        end else if (mem_ready_i) begin
            // taken this edge and no new byte behind it
            mem_we_o   <= 1'b0;
        end
    end

    always @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            state      <= ST_IDLE;
            rtype      <= 4'h0;
            alen       <= 3'h0;
            nib_lo     <= 1'b0;
            hi_nib     <= 4'h0;
            len_seen   <= 1'b0;
            len        <= 8'h00;
            idx        <= 8'h00;
            sum        <= 8'h00;
            addr       <= 32'h0000_0000;
            wr_ptr     <= 16'h0000;
            have_first <= 1'b0;
            first_addr <= 16'h0000;
            loading_o  <= 1'b0;
            done_o     <= 1'b0;
            entry_o    <= 16'h0000;
            err_o      <= 1'b0;
        end else begin
            if (take) begin
                case (state)
                    ST_IDLE: begin
                        if (fifo_data == `SRDL_CH_S) begin
                            state <= ST_TYPE;
                        end else if (is_sep(fifo_data)) begin
                            // terminators between records are dropped
                            state <= ST_IDLE;
                        end else begin
                            // stray text is dropped; before the first S1 so is everything
                            state <= ST_IDLE;
                        end
                    end
                    ST_TYPE: begin
                        rtype    <= fifo_data[3:0];
                        alen     <= addr_len(fifo_data[3:0]);
                        nib_lo   <= 1'b0;
                        len_seen <= 1'b0;
                        idx      <= 8'h00;
                        addr     <= 32'h0000_0000;
                        if (!is_digit(fifo_data)) begin
                            if (loading_o)
                                err_o <= 1'b1;
                            state <= ST_IDLE;
                        end else if (fifo_data[3:0] == `SRDL_T_DATA16) begin
                            loading_o <= 1'b1;
                            state     <= ST_BODY;
                        end else if (loading_o && fifo_data[3:0] != `SRDL_T_END16) begin
                            // mid-transfer only S1 and S9 are allowed
                            err_o <= 1'b1;
                            state <= ST_IDLE;
                        end else begin
                            // S0, S5, S2/S3, S7/S8 parsed then dropped
                            state <= ST_BODY;
                        end
                    end
                    ST_BODY: begin
                        if (!hex_ok) begin
                            // short record or garbage; before the first S1 it is ignored
                            if (loading_o)
                                err_o <= 1'b1;
                            state <= ST_IDLE;
                        end else if (!nib_lo) begin
                            hi_nib <= hex_val(fifo_data);
                            nib_lo <= 1'b1;
                        end else begin
                            nib_lo <= 1'b0;
                            if (!len_seen) begin
                                len_seen <= 1'b1;
                                len      <= cbyte;
                                sum      <= cbyte;
                                // length must at least cover address and checksum
                                if (cbyte < alen8 + 8'h01) begin
                                    if (loading_o)
                                        err_o <= 1'b1;
                                    state <= ST_IDLE;
                                end
                            end else begin
                                idx <= idx + 8'h01;
                                if (at_cksum) begin
                                    // checksum byte closes the record
                                    state <= ST_IDLE;
                                    if (sum_next != `SRDL_SUM_GOOD) begin
                                        if (loading_o)
                                            err_o <= 1'b1;
                                    end else if (is_end && loading_o) begin
                                        done_o  <= 1'b1;
                                        state   <= ST_DONE;
                                        // zero address falls back to first entry point
                                        entry_o <= (addr16 == 16'h0000) ? first_addr : addr16;
                                    end
                                end else if (idx < alen8) begin
                                    sum  <= sum_next;
                                    addr <= {addr[23:0], cbyte};
                                    if (idx == alen8 - 8'h01) begin
                                        wr_ptr <= addr_next;
                                        if (is_load && !have_first) begin
                                            have_first <= 1'b1;
                                            first_addr <= addr_next;
                                        end
                                    end
                                end else begin
                                    sum <= sum_next;
                                    if (is_load) begin
                                        // the write port sends the byte; the pointer moves on
                                        wr_ptr <= wr_ptr + 16'h0001;
                                    end
                                end
                            end
                        end
                    end
                    ST_DONE: begin
                        // transfer ended; remaining characters are drained and ignored
                        state <= ST_DONE;
                    end
                    default: state <= ST_IDLE;
                endcase
            end
        end
    end
endmodule // srdl_loader

// ==== test_srecord_download_loader.sv ====
`timescale 1ns/1ps
module test_srecord_download_loader;
    logic        sys_clk_i = 1'b0;
    logic        sys_rst_i = 1'b1;
    logic        mem_ready_i = 1'b1;
    logic        stall = 1'b0;
    logic        char_valid_i, char_ready_o, mem_we_o, loading_o, done_o, err_o, stuck;
    logic [7:0]  char_i, mem_data_o;
    logic [15:0] mem_addr_o, entry_o;
    logic [7:0]  mem [0:65535];
    int          wr_count, mismatches, compares;

    always #50 sys_clk_i = ~sys_clk_i;
    always @(negedge sys_clk_i) mem_ready_i <= stall ? ~mem_ready_i : 1'b1;
    always @(posedge sys_clk_i) if (mem_we_o && mem_ready_i) begin
        mem[mem_addr_o] <= mem_data_o;
        wr_count <= wr_count + 1;
    end
    always @(posedge stuck) begin
        mismatches++;
        report_and_stop();
    end

    srdl_loader DUT (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .char_valid_i(char_valid_i),
        .char_i(char_i), .char_ready_o(char_ready_o), .mem_we_o(mem_we_o), .mem_addr_o(mem_addr_o),
        .mem_data_o(mem_data_o), .mem_ready_i(mem_ready_i), .loading_o(loading_o), .done_o(done_o),
        .entry_o(entry_o), .err_o(err_o));
    srdl_host host (.sys_clk_i(sys_clk_i), .char_ready_i(char_ready_o), .char_valid_o(char_valid_i),
        .char_o(char_i), .stuck_o(stuck));

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic report_and_stop;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // 0: write count reached, 1: done, 2: error
    task automatic wait_until(input int sel, input int target);
        int n;
        n = 0;
        while (!(sel == 0 ? wr_count >= target : sel == 1 ? done_o === 1'b1 : err_o === 1'b1)) begin
            @(negedge sys_clk_i);
            n++;
            if (n > 400) begin
                mismatches++;
                report_and_stop();
            end
        end
    endtask

    task automatic do_reset;
        @(negedge sys_clk_i);
        sys_rst_i = 1'b1;
        stall = 1'b0;
        repeat (12) @(negedge sys_clk_i);
        check("rst_outs", {loading_o, done_o, err_o, mem_we_o, char_ready_o}, 16'h0000);
        sys_rst_i = 1'b0;
        wr_count = 0;
        @(negedge sys_clk_i);
        check("ready", char_ready_o, 1'b1);
    endtask

    task automatic t_skip_load;
        do_reset();
        stall = 1'b1;
        // junk, two headers (second with bad sum) and a stray end record
        host.send("xyz\015\nS00600004844521B\015\nS00600004844521C\nS9031234B6\015\n");
        // wider address, count and 32-bit end records are parsed and dropped before loading
        host.send("S2080000100011223381\015\nS5030001FB\nS70500000000FA\n");
        host.send("S1130000285F245F2212226A000424290008237C2A\015\nS107003000144ED492\015\n");
        wait_until(0, 20);
        check("loading", loading_o, 1'b1);
        check("err", err_o, 1'b0);
        check("done", done_o, 1'b0);
        check("first", mem[16'h0000], 8'h28);
        check("last", mem[16'h000F], 8'h7C);
        check("rec2", mem[16'h0033], 8'hD4);
        check("writes", wr_count[15:0], 16'h0014);
        host.send("S9031234B6\015\n");
        wait_until(1, 0);
        check("entry", entry_o, 16'h1234);
    endtask

    task automatic t_entry_default;
        do_reset();
        host.send("S1050100aabb94\nS9030000FC\n");
        wait_until(1, 0);
        check("lo", mem[16'h0100], 8'hAA);
        check("hi", mem[16'h0101], 8'hBB);
        check("entry", entry_o, 16'h0100);
        check("err", err_o, 1'b0);
    endtask

    task automatic t_errors;
        string bad [4] = '{"S1050100AABB95", "S1050100AAXB94", "S5030001FB", "S9030000FD"};
        for (int i = 0; i < 4; i++) begin
            do_reset();
            host.send({"S1050100AABB94\015\n", bad[i], "\015\n"});
            wait_until(2, 0);
            check("done", done_o, 1'b0);
        end
    endtask

    initial begin
        t_skip_load();
        t_entry_default();
        t_errors();
        report_and_stop();
    end
endmodule // test_srecord_download_loader

bind srdl_loader srdl_checker u_chk (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .mem_we_o(mem_we_o),
    .mem_addr_o(mem_addr_o), .mem_data_o(mem_data_o), .mem_ready_i(mem_ready_i), .loading_o(loading_o),
    .done_o(done_o), .entry_o(entry_o), .err_o(err_o));
